// ---- core/eetbc_defs.svh ----
// offsets, fields, reset values and timing counts of the receive/boost block
`ifndef EETBC_DEFS_SVH
`define EETBC_DEFS_SVH
`define EETBC_CLK_NS 8
`define EETBC_OFS_LSB_DIV 3072
`define EETBC_SETTLE_UNIT_NS 64000
`define EETBC_TIMEOUT_BASE_NS 128000
`define EETBC_ADDR_CTRL 12'h000
`define EETBC_ADDR_UPOFS 12'h004
`define EETBC_ADDR_DNOFS 12'h008
`define EETBC_ADDR_FLIGHT 12'h00c
`define EETBC_ADDR_SW1 12'h010
`define EETBC_ADDR_SW2 12'h014
`define EETBC_ADDR_STATUS 12'h018
`define EETBC_ADDR_WVRUP 12'h01c
`define EETBC_ADDR_WVRDN 12'h020
`define EETBC_ADDR_DIFFINT 12'h024
`define EETBC_ADDR_DIFFFRAC 12'h028
`define EETBC_ADDR_AVGDIFF 12'h02c
`define EETBC_ADDR_TOFUP 12'h030
`define EETBC_ADDR_TOFDN 12'h034
`define EETBC_ADDR_LAUNCH 12'h038
`define EETBC_CTRL_START 0
`define EETBC_CTRL_DIFF 1
`define EETBC_CTRL_DOWN 2
`define EETBC_CTRL_IRQEN 3
`define EETBC_ST_BUSY 0
`define EETBC_ST_TIMEOUT 1
`define EETBC_ST_DONE 2
`define EETBC_ST_ERROR 3
`define EETBC_FAIL_WORD 16'hffff
`define EETBC_FAIL_DIFF_INT 16'h7fff
`define EETBC_RST_HALF 8'h40
`define EETBC_RST_PULSES 8'h08
`define EETBC_RST_WAVE 6'h07
`define EETBC_RST_LIMIT 3'h7
`endif

// ---- core/eetbc_pkg.sv ----
// types shared by the receive/boost block
package eetbc_pkg;
    typedef struct packed {
        logic enable;
        logic startupMode;
        logic [1:0] switchingRate;
        logic [3:0] targetVoltage;
        logic [3:0] peakLimit;
    } eetbc_boost_t;
    typedef enum logic [3:0] {
        IDLE, BOOST_UP, SETTLE, LAUNCH, WAIT_HIT, FIRST_WIDTH,
        COUNT_WAVES, SECOND_WIDTH, CALC, FAIL
    } eetbc_state_t;
endpackage

// ---- core/eetbc_core.sv ----
// early-edge flight receive sequencer and boost supply control, APB slave
//
// The placing of the registers and the APB slave port were decided locally.
`include "eetbc_defs.svh"
// Overview of operation
// - offset codes count in supply/3072 steps
// - first-edge offset +127 rising, -127 falling
// - separate 7-bit first-edge offsets per direction
// - measure first hit edge width
// - switch to return offset immediately after width
// - 8-bit signed return offset per direction
// - measure selected second reference wave width
// - store first/second width ratio
// - store second width over half launch period
// - failed measurement results read ffff
// - failed difference reads 7fff and ffff
// - averaged difference skips failed measurements
// - timeout sets flag and interrupt when enabled
// - interrupt holds until status register read
// - boost on before launch, off after pulses
// - two-bit switching rate select
// - four-bit boost voltage target select
// - startup limit below threshold, normal above
// - settle delay after normal mode before launch
module eetbc_core #(
    parameter int SETTLE_UNIT_CYC = `EETBC_SETTLE_UNIT_NS / `EETBC_CLK_NS,
    parameter int TIMEOUT_BASE_CYC = `EETBC_TIMEOUT_BASE_NS / `EETBC_CLK_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive comparator and boost monitor pins
    input wire logic compIn,
    input wire logic boostGood,
    // analog controls and interrupt
    output logic signed [7:0] compOffset,
    output logic rxDirUp,
    output logic txDrive,
    output eetbc_pkg::eetbc_boost_t boostCtl,
    output logic irq
);
    // configuration
    logic irqEn_reg, diffCmd_reg, downCmd_reg;
    logic [15:0] upOfs_reg, dnOfs_reg;
    logic [5:0] waveSel_reg;
    logic [2:0] limitSel_reg;
    logic fallingEdge_reg;
    logic [1:0] swRate_reg;
    logic [3:0] voltSel_reg, limStart_reg, limNorm_reg, settle_reg;
    logic [7:0] halfPer_reg, pulses_reg;
    // sequencer
    eetbc_pkg::eetbc_state_t state_reg;
    logic [23:0] timer_reg, flight_reg;
    logic [15:0] width_reg, t1_reg, tofUp_reg, tofDn_reg;
    logic [7:0] pulseCnt_reg;
    logic [5:0] waveCnt_reg;
    logic compSync1_reg, compSync2_reg, compPrev_reg;
    logic goodSync1_reg, goodSync2_reg;
    // results and status
    logic [15:0] wvrUp_reg, wvrDn_reg, diffInt_reg, diffFrac_reg;
    logic [15:0] avgDiff_reg, tofUpRes_reg, tofDnRes_reg;
    logic timeoutFlag_reg, doneFlag_reg, errFlag_reg, avgValid_reg;

    // unsigned 4.4 ratio, saturated; zero divisor gives full scale
    function automatic logic [7:0] ratio4p4(input logic [15:0] num,
                                            input logic [15:0] den);
        logic [19:0] q;
        q = 20'hfffff;
        if (den != 16'h0000) begin
            q = {num, 4'h0} / {4'h0, den};
        end
        ratio4p4 = (q > 20'h000ff) ? 8'hff : q[7:0];
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        isMapped = (a[1:0] == 2'b00) && (a <= `EETBC_ADDR_LAUNCH);
    endfunction

    wire logic setupPh = psel & ~penable;
    wire logic accessDone = psel & penable & pready;
    wire logic wrEn = accessDone & pwrite & isMapped(paddr);
    wire logic rdStatus = accessDone & ~pwrite &
                          (paddr == `EETBC_ADDR_STATUS);
    wire logic busy = (state_reg != eetbc_pkg::IDLE);
    wire logic startReq = wrEn & (paddr == `EETBC_ADDR_CTRL) &
                          pwdata[`EETBC_CTRL_START] & ~busy;
    wire logic compRise = compSync2_reg & ~compPrev_reg;
    wire logic compFall = ~compSync2_reg & compPrev_reg;
    wire logic [23:0] limitCyc =
        24'(TIMEOUT_BASE_CYC) << limitSel_reg;
    wire logic receiving = (state_reg == eetbc_pkg::WAIT_HIT) ||
                           (state_reg == eetbc_pkg::FIRST_WIDTH) ||
                           (state_reg == eetbc_pkg::COUNT_WAVES) ||
                           (state_reg == eetbc_pkg::SECOND_WIDTH);
    wire logic timedOut = receiving && (flight_reg >= limitCyc);
    wire logic [7:0] halfEff = (halfPer_reg == 8'h00) ? 8'h01 : halfPer_reg;
    wire logic [15:0] activeOfs = rxDirUp ? upOfs_reg : dnOfs_reg;
    wire logic [15:0] diffNow = tofUp_reg - tofDn_reg;
    wire logic [15:0] avgSum = 16'((17'(avgDiff_reg) + 17'(diffNow)) >> 1);

    // two-stage synchronisers for the analog pins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            compSync1_reg <= 1'b0;
            compSync2_reg <= 1'b0;
            compPrev_reg <= 1'b0;
            goodSync1_reg <= 1'b0;
            goodSync2_reg <= 1'b0;
        end else begin
            compSync1_reg <= compIn;
            compSync2_reg <= compSync1_reg;
            compPrev_reg <= compSync2_reg;
            goodSync1_reg <= boostGood;
            goodSync2_reg <= goodSync1_reg;
        end
    end

    // apb answer: zero wait states, data latched during setup
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setupPh;
            pslverr <= setupPh & ~isMapped(paddr);
            prdata <= 32'h0000_0000;
            if (setupPh && !pwrite) begin
                unique case (paddr)
                    `EETBC_ADDR_CTRL: prdata <= {28'h0, irqEn_reg,
                        downCmd_reg, diffCmd_reg, 1'b0};
                    `EETBC_ADDR_UPOFS: prdata <= {16'h0, upOfs_reg};
                    `EETBC_ADDR_DNOFS: prdata <= {16'h0, dnOfs_reg};
                    `EETBC_ADDR_FLIGHT: prdata <= {19'h0, fallingEdge_reg,
                        1'b0, limitSel_reg, 2'h0, waveSel_reg};
                    `EETBC_ADDR_SW1: prdata <= {24'h0, voltSel_reg,
                        2'h0, swRate_reg};
                    `EETBC_ADDR_SW2: prdata <= {20'h0, settle_reg,
                        limNorm_reg, limStart_reg};
                    `EETBC_ADDR_STATUS: prdata <= {28'h0, errFlag_reg,
                        doneFlag_reg, timeoutFlag_reg, busy};
                    `EETBC_ADDR_WVRUP: prdata <= {16'h0, wvrUp_reg};
                    `EETBC_ADDR_WVRDN: prdata <= {16'h0, wvrDn_reg};
                    `EETBC_ADDR_DIFFINT: prdata <= {16'h0, diffInt_reg};
                    `EETBC_ADDR_DIFFFRAC: prdata <= {16'h0, diffFrac_reg};
                    `EETBC_ADDR_AVGDIFF: prdata <= {16'h0, avgDiff_reg};
                    `EETBC_ADDR_TOFUP: prdata <= {16'h0, tofUpRes_reg};
                    `EETBC_ADDR_TOFDN: prdata <= {16'h0, tofDnRes_reg};
                    `EETBC_ADDR_LAUNCH: prdata <= {16'h0, pulses_reg,
                        halfPer_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software configuration
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqEn_reg <= 1'b0;
            diffCmd_reg <= 1'b0;
            downCmd_reg <= 1'b0;
            upOfs_reg <= 16'h0000;
            dnOfs_reg <= 16'h0000;
            waveSel_reg <= `EETBC_RST_WAVE;
            limitSel_reg <= `EETBC_RST_LIMIT;
            fallingEdge_reg <= 1'b0;
            swRate_reg <= 2'h0;
            voltSel_reg <= 4'h0;
            limStart_reg <= 4'h0;
            limNorm_reg <= 4'h0;
            settle_reg <= 4'h0;
            halfPer_reg <= `EETBC_RST_HALF;
            pulses_reg <= `EETBC_RST_PULSES;
        end else if (wrEn) begin
            unique case (paddr)
                `EETBC_ADDR_CTRL: begin
                    irqEn_reg <= pwdata[`EETBC_CTRL_IRQEN];
                    if (!busy) begin
                        diffCmd_reg <= pwdata[`EETBC_CTRL_DIFF];
                        downCmd_reg <= pwdata[`EETBC_CTRL_DOWN];
                    end
                end
                `EETBC_ADDR_UPOFS: upOfs_reg <= {pwdata[15:8],
                    1'b0, pwdata[6:0]};
                `EETBC_ADDR_DNOFS: dnOfs_reg <= {pwdata[15:8],
                    1'b0, pwdata[6:0]};
                `EETBC_ADDR_FLIGHT: begin
                    waveSel_reg <= pwdata[5:0];
                    limitSel_reg <= pwdata[10:8];
                    fallingEdge_reg <= pwdata[12];
                end
                `EETBC_ADDR_SW1: begin
                    swRate_reg <= pwdata[1:0];
                    voltSel_reg <= pwdata[7:4];
                end
                `EETBC_ADDR_SW2: begin
                    limStart_reg <= pwdata[3:0];
                    limNorm_reg <= pwdata[7:4];
                    settle_reg <= pwdata[11:8];
                end
                `EETBC_ADDR_LAUNCH: begin
                    halfPer_reg <= pwdata[7:0];
                    pulses_reg <= pwdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // measurement sequencer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= eetbc_pkg::IDLE;
            rxDirUp <= 1'b1;
            timer_reg <= 24'h000000;
            flight_reg <= 24'h000000;
            width_reg <= 16'h0000;
            t1_reg <= 16'h0000;
            tofUp_reg <= 16'h0000;
            tofDn_reg <= 16'h0000;
            pulseCnt_reg <= 8'h00;
            waveCnt_reg <= 6'h00;
            txDrive <= 1'b0;
            compOffset <= 8'sh00;
        end else begin
            timer_reg <= timer_reg + 24'h000001;
            flight_reg <= flight_reg + 24'h000001;
            unique case (state_reg)
                eetbc_pkg::IDLE: if (startReq) begin
                    rxDirUp <= ~pwdata[`EETBC_CTRL_DOWN] |
                               pwdata[`EETBC_CTRL_DIFF];
                    state_reg <= eetbc_pkg::BOOST_UP;
                end
                eetbc_pkg::BOOST_UP: begin
                    timer_reg <= 24'h000000;
                    if (goodSync2_reg) begin
                        state_reg <= eetbc_pkg::SETTLE;
                    end
                end
                eetbc_pkg::SETTLE: begin
                    // settle code n waits n units after reaching normal mode
                    if (timer_reg >= 24'(settle_reg) *
                        24'(SETTLE_UNIT_CYC)) begin
                        state_reg <= eetbc_pkg::LAUNCH;
                        timer_reg <= 24'h000000;
                        flight_reg <= 24'h000000;
                        pulseCnt_reg <= 8'h00;
                        txDrive <= 1'b1;
                    end
                end
                eetbc_pkg::LAUNCH: begin
                    if (timer_reg[7:0] == halfEff - 8'h01) begin
                        timer_reg <= 24'h000000;
                        txDrive <= ~txDrive;
                        if (txDrive) begin
                            pulseCnt_reg <= pulseCnt_reg + 8'h01;
                        end
                        if (txDrive && pulseCnt_reg + 8'h01 >= pulses_reg)
                        begin
                            txDrive <= 1'b0;
                            state_reg <= eetbc_pkg::WAIT_HIT;
                            // first-edge offset sign follows polarity
                            compOffset <= fallingEdge_reg ?
                                8'(8'sh00 - {1'b0, activeOfs[6:0]}) :
                                {1'b0, activeOfs[6:0]};
                        end
                    end
                end
                eetbc_pkg::WAIT_HIT: if (compRise) begin
                    // flight time is the hit instant, per direction
                    if (rxDirUp) begin
                        tofUp_reg <= flight_reg[15:0];
                    end else begin
                        tofDn_reg <= flight_reg[15:0];
                    end
                    width_reg <= 16'h0001;
                    state_reg <= eetbc_pkg::FIRST_WIDTH;
                end
                eetbc_pkg::FIRST_WIDTH: begin
                    width_reg <= width_reg + 16'h0001;
                    if (compFall) begin
                        t1_reg <= width_reg;
                        compOffset <= activeOfs[15:8];
                        waveCnt_reg <= 6'h00;
                        state_reg <= eetbc_pkg::COUNT_WAVES;
                    end
                end
                eetbc_pkg::COUNT_WAVES: if (compRise) begin
                    waveCnt_reg <= waveCnt_reg + 6'h01;
                    width_reg <= 16'h0001;
                    if (waveCnt_reg + 6'h01 >= waveSel_reg) begin
                        state_reg <= eetbc_pkg::SECOND_WIDTH;
                    end
                end
                eetbc_pkg::SECOND_WIDTH: begin
                    // stop on the fall edge so t2 counts like t1
                    if (compFall) begin
                        state_reg <= eetbc_pkg::CALC;
                    end else begin
                        width_reg <= width_reg + 16'h0001;
                    end
                end
                eetbc_pkg::CALC, eetbc_pkg::FAIL: begin
                    compOffset <= 8'sh00;
                    if (diffCmd_reg && rxDirUp) begin
                        rxDirUp <= 1'b0;
                        state_reg <= eetbc_pkg::BOOST_UP;
                    end else begin
                        state_reg <= eetbc_pkg::IDLE;
                    end
                end
                default: state_reg <= eetbc_pkg::IDLE;
            endcase
            if (timedOut) begin
                state_reg <= eetbc_pkg::FAIL;
            end
        end
    end

    // result registers, loaded at the end of each direction
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wvrUp_reg <= 16'h0000;
            wvrDn_reg <= 16'h0000;
            tofUpRes_reg <= 16'h0000;
            tofDnRes_reg <= 16'h0000;
            diffInt_reg <= 16'h0000;
            diffFrac_reg <= 16'h0000;
            avgDiff_reg <= 16'h0000;
            avgValid_reg <= 1'b0;
        end else if (state_reg == eetbc_pkg::CALC && !timedOut) begin
            if (rxDirUp) begin
                wvrUp_reg <= {ratio4p4(t1_reg, width_reg),
                    ratio4p4(width_reg, {8'h00, halfEff})};
                tofUpRes_reg <= tofUp_reg;
            end else begin
                wvrDn_reg <= {ratio4p4(t1_reg, width_reg),
                    ratio4p4(width_reg, {8'h00, halfEff})};
                tofDnRes_reg <= tofDn_reg;
            end
            if (diffCmd_reg && !rxDirUp && !errFlag_reg) begin
                diffInt_reg <= diffNow;
                diffFrac_reg <= 16'h0000;
                // running mean of successful differences only
                avgDiff_reg <= avgValid_reg ? avgSum : diffNow;
                avgValid_reg <= 1'b1;
            end else if (diffCmd_reg && !rxDirUp) begin
                diffInt_reg <= `EETBC_FAIL_DIFF_INT;
                diffFrac_reg <= `EETBC_FAIL_WORD;
            end
        end else if (state_reg == eetbc_pkg::FAIL || timedOut) begin
            if (rxDirUp) begin
                wvrUp_reg <= `EETBC_FAIL_WORD;
                tofUpRes_reg <= `EETBC_FAIL_WORD;
            end else begin
                wvrDn_reg <= `EETBC_FAIL_WORD;
                tofDnRes_reg <= `EETBC_FAIL_WORD;
            end
            if (diffCmd_reg) begin
                diffInt_reg <= `EETBC_FAIL_DIFF_INT;
                diffFrac_reg <= `EETBC_FAIL_WORD;
            end
        end
    end

    // status flags and interrupt; a set in the clearing cycle wins
    wire logic finishing = (state_reg == eetbc_pkg::CALC ||
        state_reg == eetbc_pkg::FAIL) && !(diffCmd_reg && rxDirUp);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timeoutFlag_reg <= 1'b0;
            doneFlag_reg <= 1'b0;
            errFlag_reg <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (timedOut) begin
                timeoutFlag_reg <= 1'b1;
            end else if (rdStatus) begin
                timeoutFlag_reg <= 1'b0;
            end
            if (finishing) begin
                doneFlag_reg <= 1'b1;
            end else if (rdStatus) begin
                doneFlag_reg <= 1'b0;
            end
            if (startReq) begin
                errFlag_reg <= 1'b0;
            end else if (timedOut) begin
                errFlag_reg <= 1'b1;
            end
            if (irqEn_reg && (timedOut || finishing)) begin
                irq <= 1'b1;
            end else if (rdStatus) begin
                irq <= 1'b0;
            end
        end
    end

    // boost drive: on from start until the last launch pulse
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            boostCtl <= '0;
        end else begin
            boostCtl.enable <= (state_reg == eetbc_pkg::BOOST_UP) ||
                (state_reg == eetbc_pkg::SETTLE) ||
                (state_reg == eetbc_pkg::LAUNCH);
            boostCtl.startupMode <= ~goodSync2_reg;
            boostCtl.peakLimit <= goodSync2_reg ? limNorm_reg :
                                  limStart_reg;
            boostCtl.switchingRate <= swRate_reg;
            boostCtl.targetVoltage <= voltSel_reg;
        end
    end
endmodule

// ---- tb/eetbc_core_properties.sv ----
// concurrent checks on the pins of the receive/boost block
`include "eetbc_defs.svh"
module eetbc_core_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic compIn,
    input wire logic boostGood,
    input wire logic signed [7:0] compOffset,
    input wire logic rxDirUp,
    input wire logic txDrive,
    input wire eetbc_pkg::eetbc_boost_t boostCtl,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic apbWr;
    logic stRead;
    assign apbWr = psel && pwrite;
    assign stRead = psel && penable && !pwrite
        && paddr == `EETBC_ADDR_STATUS;
    // windows cover the two-flop sync plus the output register
    sequence s_low;
        boostCtl.enable && !boostGood [*4];
    endsequence
    sequence s_good;
        boostCtl.enable && boostGood [*5];
    endsequence
    property p_tx_boost;
        txDrive |-> boostCtl.enable;
    endproperty
    // a held nonzero offset marks the receive window
    property p_rx_quiet;
        compOffset != 8'sh00 && $past(compOffset) != 8'sh00
            |-> !boostCtl.enable;
    endproperty
    property p_startup;
        s_low |-> boostCtl.startupMode;
    endproperty
    property p_normal;
        s_good |-> !boostCtl.startupMode;
    endproperty
    property p_settle;
        s_low |-> !txDrive;
    endproperty
    property p_irq_hold;
        $fell(irq) |-> $past(stRead) || $past(stRead, 2);
    endproperty
    property p_rate_hold;
        boostCtl.enable && $past(boostCtl.enable) && !$past(apbWr)
            && !$past(apbWr, 2) |-> $stable(boostCtl.switchingRate);
    endproperty
    property p_volt_hold;
        boostCtl.enable && $past(boostCtl.enable) && !$past(apbWr)
            && !$past(apbWr, 2) |-> $stable(boostCtl.targetVoltage);
    endproperty
    a_tx_boost: assert property (p_tx_boost)
        else $error("launch while boost off");
    a_rx_quiet: assert property (p_rx_quiet)
        else $error("boost on during reception");
    a_startup: assert property (p_startup)
        else $error("not in startup limit while low");
    a_normal: assert property (p_normal)
        else $error("still in startup limit when good");
    a_settle: assert property (p_settle)
        else $error("launch before supply good");
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq dropped without status read");
    a_rate_hold: assert property (p_rate_hold)
        else $error("switching rate moved while on");
    a_volt_hold: assert property (p_volt_hold)
        else $error("target voltage moved while on");
endmodule
bind eetbc_core eetbc_core_properties u_eetbc_core_properties (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .compIn, .boostGood, .compOffset, .rxDirUp,
    .txDrive, .boostCtl, .irq);

// ---- tb/eetbc_partner.sv ----
// far side model: boost power-good monitor and receive comparator
module eetbc_partner (
    // clock
    input wire logic clk,
    // scenario control, low means no echo ever arrives
    input wire logic answer,
    // block outputs
    input wire eetbc_pkg::eetbc_boost_t boostCtl,
    // modelled pins
    output logic compIn,
    output logic boostGood
);
    timeunit 1ns;
    timeprecision 1ps;
    int upCnt = 0;
    int rxCnt = -1;
    logic enPrev = 1'b0;
    initial compIn = 1'b0;
    initial boostGood = 1'b0;
    // supply good drops at once when switched off, unlike a real rail
    always @(posedge clk) begin
        upCnt <= boostCtl.enable ? upCnt + 1 : 0;
        boostGood <= boostCtl.enable && upCnt >= 5;
    end
    // echo 14 cycles after boost off: six waves, 4 high and 4 low
    always @(posedge clk) begin
        enPrev <= boostCtl.enable;
        if (enPrev && !boostCtl.enable && answer)
            rxCnt <= 0;
        else if (rxCnt >= 0 && rxCnt < 60)
            rxCnt <= rxCnt + 1;
        else
            rxCnt <= -1;
        compIn <= rxCnt >= 12 && rxCnt < 60 && ((rxCnt - 12) % 8) < 4;
    end
endmodule

// ---- tb/early_edge_tof_boost_control_tb_top.sv ----
// self-checking bench for the receive sequencer and boost control
`include "eetbc_defs.svh"
module early_edge_tof_boost_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, compIn, boostGood, rxDirUp, txDrive, irq;
    logic signed [7:0] compOffset;
    eetbc_pkg::eetbc_boost_t boost;
    logic answer = 1'b1;
    logic [31:0] rdat;
    logic err;
    int fail_count = 0;
    int check_count = 0;
    always #4 clk = ~clk;
    eetbc_core #(.SETTLE_UNIT_CYC(4), .TIMEOUT_BASE_CYC(64)) u_eetbc_core (
        .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .compIn, .boostGood, .compOffset, .rxDirUp,
        .txDrive, .boostCtl(boost), .irq);
    eetbc_partner u_eetbc_partner (.clk, .answer, .boostCtl(boost),
        .compIn, .boostGood);
    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one clock of idle after each transfer keeps strobes single-driven
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
        input string what);
        apb(1'b0, a, 32'h0);
        check(what, rdat, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
    initial begin
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        rd(`EETBC_ADDR_FLIGHT, 32'h707, "flight reset");
        rd(`EETBC_ADDR_LAUNCH, 32'h840, "launch reset");
        rd(12'h03c, 32'h0, "unmapped data");
        check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, `EETBC_ADDR_UPOFS, 32'hf010);
        apb(1'b1, `EETBC_ADDR_DNOFS, 32'he020);
        apb(1'b1, `EETBC_ADDR_FLIGHT, 32'h102);
        apb(1'b1, `EETBC_ADDR_SW1, 32'ha2);
        apb(1'b1, `EETBC_ADDR_SW2, 32'h153);
        apb(1'b1, `EETBC_ADDR_LAUNCH, 32'h204);
        apb(1'b1, `EETBC_ADDR_CTRL, 32'h9);
        wait (boost.enable === 1'b1);
        tick(2);
        check("boost startup", {20'h0, boost}, 32'hea3);
        wait (boost.startupMode === 1'b0);
        tick(2);
        check("boost normal", {20'h0, boost}, 32'haa5);
        wait (boost.enable === 1'b0);
        tick(4);
        check("first up", {23'h0, rxDirUp, compOffset}, 32'h110);
        wait (compIn === 1'b1);
        wait (compIn === 1'b0);
        tick(6);
        check("return up", {24'h0, compOffset}, 32'hf0);
        wait (irq === 1'b1);
        tick(1);
        rd(`EETBC_ADDR_STATUS, 32'h4, "status done");
        rd(`EETBC_ADDR_WVRUP, 32'h1010, "ratio up");
        tick(1);
        check("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b1, `EETBC_ADDR_CTRL, 32'hb);
        wait (rxDirUp === 1'b0);
        wait (boost.enable === 1'b1);
        wait (boost.enable === 1'b0);
        tick(4);
        check("first dn", {23'h0, rxDirUp, compOffset}, 32'h20);
        wait (irq === 1'b1);
        tick(1);
        rd(`EETBC_ADDR_DIFFINT, 32'h0, "diff ok");
        rd(`EETBC_ADDR_AVGDIFF, 32'h0, "avg ok");
        rd(`EETBC_ADDR_STATUS, 32'h4, "status diff");
        check("irq diff", {31'h0, irq}, 32'h0);
        answer <= 1'b0;
        apb(1'b1, `EETBC_ADDR_FLIGHT, 32'h2);
        apb(1'b1, `EETBC_ADDR_CTRL, 32'hb);
        wait (irq === 1'b1);
        tick(1);
        apb(1'b0, `EETBC_ADDR_STATUS, 32'h0);
        check("timeout flag", {31'h0, rdat[1]}, 32'h1);
        rd(`EETBC_ADDR_WVRUP, 32'hffff, "ratio fail");
        rd(`EETBC_ADDR_TOFUP, 32'hffff, "flight fail");
        rd(`EETBC_ADDR_DIFFINT, 32'h7fff, "diff int fail");
        rd(`EETBC_ADDR_DIFFFRAC, 32'hffff, "diff frac fail");
        rd(`EETBC_ADDR_AVGDIFF, 32'h0, "avg skip");
        give_verdict();
    end
endmodule
